// >>> logic/synth_cfg_pkg.sv
// Purpose: Shared constants for the loop-table and gain-lock config block.
// Assumes: Byte-wide registers reached at their printed offsets.
// Notes: The status offset and table contents are local conventions.
package synth_cfg_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam logic [9:0] ADDR_TRIM_HIGH = 10'h112;
    localparam logic [9:0] ADDR_LOOP_GAIN = 10'h113;
    localparam logic [9:0] ADDR_STATUS = 10'h3F0;
    localparam int GAIN_MSB = 7;
    localparam int GAIN_LSB = 6;
    localparam int SRC_MSB = 5;
    localparam int SRC_LSB = 4;
    localparam int TRIML_MSB = 3;
    localparam int TRIML_LSB = 0;
    localparam int TRIMH_MSB = 7;
    localparam int TRIMH_LSB = 2;
    localparam logic [7:0] LOOP_GAIN_RST = 8'h00;
    localparam logic [7:0] TRIM_HIGH_RST = 8'h00;
    localparam int TABLE_LEN = 9;
    localparam logic [7:0] PKT_TABLE_FIRST = 8'h10;
    localparam logic [7:0] PKT_TABLE_LAST = 8'h18;
    localparam logic [3:0] LAST_IDX = 4'h8;
    // Data rate is held in units of 100 bps.
    localparam logic [11:0] RATE_SLOW = 12'h064;
    localparam logic [11:0] RATE_MID = 12'h1F4;
    localparam logic [11:0] RATE_FAST = 12'h3E8;
    localparam logic [2:0] MOD_OOK = 3'h2;
    localparam logic [2:0] RX_CLASS = 3'h0;
    localparam logic [7:0] RX_BASE = 8'h10;
    localparam logic [7:0] RX_STEP = 8'h02;
    localparam logic [7:0] TX_STEP = 8'h04;
    localparam logic [7:0] TX_BASE [8] = '{8'h20, 8'h30, 8'h40, 8'h50,
                                          8'h28, 8'h38, 8'h48, 8'h58};

    typedef enum logic [1:0] {
        GAIN_FREE = 2'h0,
        GAIN_MANUAL = 2'h1,
        GAIN_HOLD = 2'h2,
        GAIN_LOCK_SYNC = 2'h3
    } gain_lock_e;
endpackage

// >>> logic/loop_rom_if.sv
// Purpose: Read port between the table loader and the loop-table ROM.
// Assumes: Data answers one clock after a read request.
// Notes: bw_class selects among the transmit tables.
`timescale 1ns/1ps
interface loop_rom_if;
    logic rd_en;
    logic is_tx;
    logic [2:0] bw_class;
    logic [3:0] idx;
    logic [7:0] data;
    modport loader (output rd_en, output is_tx, output bw_class,
                    output idx, input data);
    modport rom (input rd_en, input is_tx, input bw_class, input idx,
                 output data);
endinterface

// >>> logic/loop_table_rom.sv
// Purpose: Predefined receive and transmit synthesizer loop tables.
// Assumes: One request per cycle, answer registered one cycle later.
// Notes: Contents are generated from base and step constants.
`timescale 1ns/1ps
module loop_table_rom (
    input wire logic clk,
    input wire logic arst_n,
    loop_rom_if.rom bus
);
    logic [7:0] data_q;
    logic [7:0] idx_w;

    assign idx_w = {4'h0, bus.idx};
    assign bus.data = data_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= 8'h00;
        end else if (bus.rd_en) begin
            if (bus.is_tx) begin
                data_q <= 8'(synth_cfg_pkg::TX_BASE[bus.bw_class]
                          + idx_w * synth_cfg_pkg::TX_STEP);
            end else begin
                data_q <= 8'(synth_cfg_pkg::RX_BASE
                          + idx_w * synth_cfg_pkg::RX_STEP);
            end
        end
    end
endmodule

// >>> logic/synth_loop_gain_config.sv
// Purpose: Gain-lock selection and synthesizer loop-table source logic.
// Assumes: Entry pulses, rate and detect inputs share this clock.
// Notes: Each entry into transmit or receive streams nine table bytes unless another entry restarts the load first.
// Operation
// RQ1: Gain field codes free, manual, hold, lock.
// RQ2: Source 0 loads ROM tables on entry.
// RQ3: Receive narrow; transmit by rate and modulation.
// RQ4: Source 1: receive from trims, transmit ROM.
// RQ5: Source 2: transmit from packet RAM 0x10-0x18.
// RQ6: Source 3: both custom tables used.
// RQ7: Host rewrites packet RAM table after sleep.
// RQ8: Low trim zero unless source 1 or 3.
// RQ9: High trim zero unless source 1 or 3.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module synth_loop_gain_config (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic enter_tx,
    input wire logic enter_rx,
    input wire logic [11:0] data_rate,
    input wire logic [2:0] mod_select,
    input wire logic sync_detect,
    output logic [1:0] gain_lock_select,
    output logic gain_frozen,
    output logic pkt_rd_en,
    output logic [7:0] pkt_rd_addr,
    input wire logic [7:0] pkt_rd_data,
    output logic table_wr_en,
    output logic [3:0] table_wr_idx,
    output logic [7:0] table_wr_data,
    output logic table_is_tx,
    output logic table_ready
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ} load_state_e;

    logic [7:0] loop_gain_q;
    logic [7:0] trim_high_q;
    logic [7:0] rdata_q;
    load_state_e state_q;
    logic [3:0] idx_q;
    logic tx_q;
    logic [1:0] src_q;
    logic [2:0] tx_class_q;
    logic cap_vld_q;
    logic [3:0] cap_idx_q;
    logic lock_q;
    logic wr_en_q;
    logic [3:0] wr_idx_q;
    logic [7:0] wr_data_q;
    logic ready_q;
    logic [7:0] trim_sum;
    logic [7:0] cap_byte;
    logic start;
    logic [1:0] src_now;

    loop_rom_if rom_bus ();

    loop_table_rom loop_table_rom_i (
        .clk(clk),
        .arst_n(arst_n),
        .bus(rom_bus)
    );

    // Maps rate and modulation to one of eight transmit bandwidth tables.
    function automatic logic [2:0] tx_class(input logic [11:0] rate,
                                            input logic [2:0] mode);
        logic [1:0] band;
        band = 2'h3;
        if (rate <= synth_cfg_pkg::RATE_SLOW) begin
            band = 2'h0;
        end else if (rate <= synth_cfg_pkg::RATE_MID) begin
            band = 2'h1;
        end else if (rate <= synth_cfg_pkg::RATE_FAST) begin
            band = 2'h2;
        end
        return {mode == synth_cfg_pkg::MOD_OOK, band};
    endfunction

    assign src_now = loop_gain_q[synth_cfg_pkg::SRC_MSB:
                                 synth_cfg_pkg::SRC_LSB];
    assign start = enter_tx | enter_rx;

    // Register port.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_gain_q <= synth_cfg_pkg::LOOP_GAIN_RST;
            trim_high_q <= synth_cfg_pkg::TRIM_HIGH_RST;
        end else if (wr) begin
            if (addr == synth_cfg_pkg::ADDR_LOOP_GAIN) begin
                loop_gain_q <= wdata;
            end
            if (addr == synth_cfg_pkg::ADDR_TRIM_HIGH) begin
                trim_high_q <= wdata;
            end
        end
    end

    // Unmapped addresses read as zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                synth_cfg_pkg::ADDR_LOOP_GAIN: begin
                    rdata_q <= loop_gain_q;
                end
                synth_cfg_pkg::ADDR_TRIM_HIGH: begin
                    rdata_q <= trim_high_q;
                end
                synth_cfg_pkg::ADDR_STATUS: begin
                    rdata_q <= {4'h0, gain_frozen, tx_q,
                                state_q == ST_READ, ready_q};
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end
    assign rdata = rdata_q;

    // Gain locking. A detect in the same cycle as a new entry still locks.
    assign gain_lock_select = loop_gain_q[synth_cfg_pkg::GAIN_MSB:
                                          synth_cfg_pkg::GAIN_LSB];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_q <= 1'b0;
        end else if (sync_detect && gain_lock_select ==
                     synth_cfg_pkg::GAIN_LOCK_SYNC) begin // see RQ1
            lock_q <= 1'b1;
        end else if (start ||
                     gain_lock_select != synth_cfg_pkg::GAIN_LOCK_SYNC) begin
            lock_q <= 1'b0;
        end
    end
    // Manual and hold both stop the loop from tracking; lock waits for sync.
    assign gain_frozen = (gain_lock_select == synth_cfg_pkg::GAIN_MANUAL)
        | (gain_lock_select == synth_cfg_pkg::GAIN_HOLD)
        | lock_q; // see RQ1

    // Loader. Source, rate and modulation are sampled at entry so a mid-load write cannot mix
    // two sources inside one table. Transmit wins if both entries coincide.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            idx_q <= 4'h0;
            tx_q <= 1'b0;
            src_q <= 2'h0;
            tx_class_q <= 3'h0;
        end else if (start) begin
            state_q <= ST_READ; // see RQ2
            idx_q <= 4'h0;
            tx_q <= enter_tx;
            src_q <= src_now;
            tx_class_q <= tx_class(data_rate, mod_select); // see RQ3
        end else begin
            case (state_q)
                ST_READ: begin
                    idx_q <= 4'(idx_q + 4'h1);
                    if (idx_q == synth_cfg_pkg::LAST_IDX) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Receive always uses the narrow class; transmit uses the rate class.
    assign rom_bus.rd_en = state_q == ST_READ;
    assign rom_bus.is_tx = tx_q;
    assign rom_bus.bw_class = tx_q ? tx_class_q
                                   : synth_cfg_pkg::RX_CLASS; // see RQ3
    assign rom_bus.idx = idx_q;

    // Packet RAM is read only for a custom transmit table.
    assign pkt_rd_en = state_q == ST_READ && tx_q && src_q[1]; // see RQ5
    assign pkt_rd_addr = 8'(synth_cfg_pkg::PKT_TABLE_FIRST
                         + {4'h0, idx_q}); // see RQ5

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_vld_q <= 1'b0;
            cap_idx_q <= 4'h0;
        end else begin
            cap_vld_q <= state_q == ST_READ && !start;
            cap_idx_q <= idx_q;
        end
    end

    // Custom receive shifts the narrow ROM table by both trims.
    assign trim_sum = 8'({2'h0, trim_high_q[synth_cfg_pkg::TRIMH_MSB:
                                            synth_cfg_pkg::TRIMH_LSB]}
        + {4'h0, loop_gain_q[synth_cfg_pkg::TRIML_MSB:
                             synth_cfg_pkg::TRIML_LSB]});

    always_comb begin
        cap_byte = rom_bus.data; // see RQ2
        if (tx_q && src_q[1]) begin
            cap_byte = pkt_rd_data; // see RQ5 RQ6
        end else if (!tx_q && src_q[0]) begin
            cap_byte = 8'(rom_bus.data + trim_sum); // see RQ4 RQ6
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_en_q <= 1'b0;
            wr_idx_q <= 4'h0;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= cap_vld_q && !start;
            if (cap_vld_q) begin
                wr_idx_q <= cap_idx_q;
                wr_data_q <= cap_byte;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_q <= 1'b0;
        end else if (start) begin
            ready_q <= 1'b0;
        end else if (cap_vld_q && cap_idx_q == synth_cfg_pkg::LAST_IDX) begin
            ready_q <= 1'b1;
        end
    end

    assign table_wr_en = wr_en_q;
    assign table_wr_idx = wr_idx_q;
    assign table_wr_data = wr_data_q;
    assign table_is_tx = tx_q;
    assign table_ready = ready_q;

    gain_lock_a: assert property ( // see RQ1
        @(posedge clk) disable iff (!arst_n)
        sync_detect && gain_lock_select == 2'h3
            |=> gain_frozen || gain_lock_select != 2'h3)
        else $error("Sync detect did not lock the gain.");

    gain_free_a: assert property ( // see RQ1
        @(posedge clk) disable iff (!arst_n)
        gain_lock_select == 2'h0 && $past(gain_lock_select) == 2'h0
            |-> !gain_frozen)
        else $error("Gain frozen while free running.");

    lock_clear_a: assert property ( // see RQ1
        @(posedge clk) disable iff (!arst_n)
        start && !sync_detect |=> !lock_q)
        else $error("Gain lock survived a new entry.");

    load_start_a: assert property ( // see RQ2
        @(posedge clk) disable iff (!arst_n)
        start |=> state_q == ST_READ && idx_q == 4'h0 && !table_ready)
        else $error("Entry did not start a table load.");

    load_done_a: assert property ( // see RQ2
        @(posedge clk) disable iff (!arst_n)
        start ##1 (!start) [*8] ##1 !start ##1 !start
            |=> table_ready && table_wr_en && table_wr_idx == 4'h8)
        else $error("Table load did not finish in eleven cycles.");

    load_abort_a: assert property ( // see RQ2
        @(posedge clk) disable iff (!arst_n)
        start |=> !table_wr_en ##1 !table_wr_en)
        else $error("Old table byte written after a new entry.");

    rx_narrow_a: assert property ( // see RQ3
        @(posedge clk) disable iff (!arst_n)
        rom_bus.rd_en && !tx_q |-> rom_bus.bw_class == 3'h0)
        else $error("Receive did not use the narrow table.");

    tx_class_a: assert property ( // see RQ3
        @(posedge clk) disable iff (!arst_n)
        enter_tx |=> tx_class_q == {$past(mod_select) == 3'h2,
            2'($past(data_rate) > 12'h064) + 2'($past(data_rate) > 12'h1F4)
            + 2'($past(data_rate) > 12'h3E8)})
        else $error("Transmit class does not follow rate settings.");

    rx_trim_a: assert property ( // see RQ4
        @(posedge clk) disable iff (!arst_n)
        cap_vld_q && !start && !tx_q && src_q[0] |=> table_wr_data
            == 8'($past(rom_bus.data) + $past(trim_sum)))
        else $error("Custom receive byte not built from trims.");

    tx_pkt_a: assert property ( // see RQ5
        @(posedge clk) disable iff (!arst_n)
        rom_bus.rd_en && tx_q && src_q[1] |-> pkt_rd_en
            && pkt_rd_addr <= 8'h18 && pkt_rd_addr >= 8'h10)
        else $error("Custom transmit did not read packet RAM.");

    pkt_only_tx_a: assert property ( // see RQ6
        @(posedge clk) disable iff (!arst_n)
        pkt_rd_en |-> tx_q && src_q[1])
        else $error("Packet RAM read outside custom transmit.");
endmodule

// >>> verif/pkt_ram_model.sv
// Purpose: Packet RAM read port holding a custom transmit loop table.
// Assumes: Data answers one clock after a read request.
// Notes: Outside a read the data line toggles so stale bytes never pass.
`timescale 1ns/1ps
module pkt_ram_model (
    input wire logic clk,
    input wire logic pkt_rd_en,
    input wire logic [7:0] pkt_rd_addr,
    output logic [7:0] pkt_rd_data
);
    logic [7:0] data_q = 8'h00;

    assign pkt_rd_data = data_q;
    // Table bytes are a fixed pattern, as if rewritten after wake.
    always @(posedge clk) begin
        if (pkt_rd_en && pkt_rd_addr >= 8'h10 && pkt_rd_addr <= 8'h18) begin
            data_q <= pkt_rd_addr ^ 8'h5A;
        end else begin
            data_q <= ~data_q;
        end
    end
endmodule

// >>> verif/synth_loop_gain_config_tb_top.sv
// Purpose: Self-checking bench for the loop-table and gain-lock block.
// Assumes: Packet RAM answers one cycle after a read request.
// Notes: Each load is collected byte by byte and checked as it arrives.
`timescale 1ns/1ps
module synth_loop_gain_config_tb_top;
    logic clk, arst_n, wr, rd, enter_tx, enter_rx, sync_detect;
    logic gain_frozen, pkt_rd_en, table_wr_en, table_is_tx, table_ready;
    logic [9:0] addr;
    logic [7:0] wdata, rdata, pkt_rd_addr, pkt_rd_data, table_wr_data;
    logic [7:0] th, tl, got;
    logic [11:0] data_rate;
    logic [2:0] mod_select, cls_v;
    logic [1:0] gain_lock_select, src_v;
    logic [3:0] table_wr_idx;
    int n_fail, comparisons;

    synth_loop_gain_config synth_loop_gain_config_i (.clk(clk),
        .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .enter_tx(enter_tx), .enter_rx(enter_rx),
        .data_rate(data_rate), .mod_select(mod_select),
        .sync_detect(sync_detect), .gain_lock_select(gain_lock_select),
        .gain_frozen(gain_frozen), .pkt_rd_en(pkt_rd_en),
        .pkt_rd_addr(pkt_rd_addr), .pkt_rd_data(pkt_rd_data),
        .table_wr_en(table_wr_en), .table_wr_idx(table_wr_idx),
        .table_wr_data(table_wr_data), .table_is_tx(table_is_tx),
        .table_ready(table_ready));
    pkt_ram_model pkt_ram_model_i (.clk(clk), .pkt_rd_en(pkt_rd_en),
        .pkt_rd_addr(pkt_rd_addr), .pkt_rd_data(pkt_rd_data));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t byte got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t flag got %b expected %b", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [9:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    task automatic cfg(input logic [1:0] m, input logic [1:0] s,
                       input logic [5:0] h, input logic [3:0] l);
        src_v = s;
        th = {2'h0, h};
        tl = {4'h0, l};
        wr_reg(synth_cfg_pkg::ADDR_TRIM_HIGH, {h, 2'h0});
        wr_reg(synth_cfg_pkg::ADDR_LOOP_GAIN, {m, s, l});
    endtask

    function automatic logic [7:0] expv(input logic tx, input logic [3:0] i);
        if (tx && src_v[1]) return (8'h10 + 8'(i)) ^ 8'h5A;
        if (tx) return synth_cfg_pkg::TX_BASE[cls_v] + 8'(i) * 8'h04;
        return 8'h10 + 8'(i) * 8'h02 + (src_v[0] ? th + tl : 8'h00);
    endfunction

    task automatic load(input logic tx);
        int n;
        int first;
        n = 0;
        first = 0;
        @(posedge clk);
        enter_tx <= tx;
        enter_rx <= ~tx;
        @(posedge clk);
        enter_tx <= 1'b0;
        enter_rx <= 1'b0;
        for (int c = 1; c < 14; c++) begin
            @(posedge clk);
            #1;
            if (table_wr_en === 1'b1) begin
                if (n == 0) first = c;
                chk8({4'h0, table_wr_idx}, 8'(n));
                chk8(table_wr_data, expv(tx, 4'(n)));
                n++;
            end
        end
        chk8(8'(n), 8'h09);
        // Looking just after the launching edge sees each byte one cycle
        // before the edge that samples it, so cycle 3 shows up here as 2.
        chk8(8'(first), 8'h02);
        chk1(table_ready, 1'b1);
        chk1(table_is_tx, tx);
    endtask

    task automatic t_regs;
        rd_reg(synth_cfg_pkg::ADDR_LOOP_GAIN);
        chk8(got, synth_cfg_pkg::LOOP_GAIN_RST);
        cfg(2'h3, 2'h1, 6'h2A, 4'h5);
        rd_reg(synth_cfg_pkg::ADDR_LOOP_GAIN);
        chk8(got, 8'hD5);
        rd_reg(synth_cfg_pkg::ADDR_TRIM_HIGH);
        chk8(got, 8'hA8);
        rd_reg(10'h200);
        chk8(got, 8'h00);
        $display("t_regs done");
    endtask

    task automatic t_gain;
        for (int m = 0; m < 4; m++) begin
            cfg(2'(m), 2'h0, 6'h00, 4'h0);
            #1 chk8({6'h00, gain_lock_select}, 8'(m));
            chk1(gain_frozen, m == 1 || m == 2);
        end
        @(posedge clk);
        sync_detect <= 1'b1;
        @(posedge clk);
        sync_detect <= 1'b0;
        @(posedge clk);
        #1 chk1(gain_frozen, 1'b1);
        $display("t_gain done");
    endtask

    task automatic t_tables;
        data_rate <= synth_cfg_pkg::RATE_FAST;
        mod_select <= synth_cfg_pkg::MOD_OOK;
        cls_v = 3'h6;
        cfg(2'h0, 2'h0, 6'h00, 4'h0);
        load(1'b0);
        load(1'b1);
        data_rate <= 12'h065;
        mod_select <= 3'h0;
        cls_v = 3'h1;
        cfg(2'h0, 2'h1, 6'h3F, 4'hF);
        load(1'b0);
        load(1'b1);
        cfg(2'h0, 2'h2, 6'h00, 4'h0);
        load(1'b1);
        load(1'b0);
        cfg(2'h0, 2'h3, 6'h01, 4'h2);
        @(posedge clk);
        enter_tx <= 1'b1;
        @(posedge clk);
        enter_tx <= 1'b0;
        repeat (4) @(posedge clk);
        load(1'b0);
        load(1'b1);
        rd_reg(synth_cfg_pkg::ADDR_STATUS);
        chk8(got, 8'h05);
        $display("t_tables done");
    endtask

    task automatic wrap_up;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #80000;
        n_fail++;
        wrap_up();
    end

    initial begin
        n_fail = 0;
        comparisons = 0;
        arst_n = 1'b0;
        {wr, rd, enter_tx, enter_rx, sync_detect} = 5'h00;
        addr = 10'h000;
        wdata = 8'h00;
        data_rate = 12'h000;
        mod_select = 3'h0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_gain();
        t_tables();
        wrap_up();
    end
endmodule
